/* verilog/smbus_sensor_slave.sv */
// Purpose: two-wire slave, pointer registers and conversion sequencing
// Assumes: scl and sda are asynchronous pins; comparators run on mclk
// Notes: open-drain pins use output level plus active-low enable
`timescale 1ns/10ps
module smbus_sensor_slave #(
   parameter bit VARIANT_B = 1'b0,
   parameter int TIMEOUT_CYCLES = smbus_sensor_pkg::TIMEOUT_CYC,
   parameter int CONV_CYCLES = smbus_sensor_pkg::CONV_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // alarm pins
   output logic alert_o,
   output logic alert_oe_n,
   output logic overtemp_trip_out_n,
   output logic overtemp_trip_oe_n,
   // measurement side
   input wire logic supply_ok,
   input wire logic [7:0] local_meas,
   input wire logic [7:0] remote_meas,
   input wire logic alert_cond,
   input wire logic alert_high,
   input wire logic overtemp_cond,
   output logic conv_busy
);
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_AACK = 8'h04,
      ST_WR = 8'h08,
      ST_WACK = 8'h10,
      ST_RD = 8'h20,
      ST_RACK = 8'h40,
      ST_IGN = 8'h80
   } bus_st_t;

   typedef struct packed {
      logic scl_m, scl_s, sda_m, sda_s;
      logic scl_f, sda_f, scl_p, sda_p;
      logic [2:0] scl_cnt, sda_cnt;
      logic hs;
      bus_st_t st;
      logic [3:0] bits;
      logic [7:0] sh;
      logic [7:0] tx;
      logic first, rd, gc, ara, nbyte, mack;
      logic in_xfer;
      logic [smbus_sensor_pkg::TO_W-1:0] to_cnt;
      logic [7:0] ptr, cfg, local_res, remote_res;
      logic conv_on, single, shot_req, hold;
      logic [smbus_sensor_pkg::CV_W-1:0] cv_cnt;
      logic sda_oe_n, alert_oe_n, trip_oe_n, pin_low;
   } state_t;

   state_t s;
   state_t n;
   logic rise, fall, start, stop, sw_rst, alert_on;
   logic [2:0] lim;
   logic [6:0] own;
   logic [7:0] rdb;

   assign own = VARIANT_B ? smbus_sensor_pkg::ADDR_B : smbus_sensor_pkg::ADDR_A;

   // all next-state logic
   always_comb begin
      n = s;
      sw_rst = 1'b0;
      // two-stage synchronisers
      n.scl_m = scl_i;
      n.scl_s = s.scl_m;
      n.sda_m = sda_i;
      n.sda_s = s.sda_m;
      // spike filters, span shortened in high-speed
      lim = s.hs ? smbus_sensor_pkg::FILT_HS : smbus_sensor_pkg::FILT_FAST;
      if (s.scl_s == s.scl_f) begin
         n.scl_cnt = 3'h0;
      end else if (s.scl_cnt >= lim) begin
         n.scl_f = s.scl_s;
         n.scl_cnt = 3'h0;
      end else begin
         n.scl_cnt = s.scl_cnt + 3'h1;
      end
      if (s.sda_s == s.sda_f) begin
         n.sda_cnt = 3'h0;
      end else if (s.sda_cnt >= lim) begin
         n.sda_f = s.sda_s;
         n.sda_cnt = 3'h0;
      end else begin
         n.sda_cnt = s.sda_cnt + 3'h1;
      end
      n.scl_p = s.scl_f;
      n.sda_p = s.sda_f;
      // bus events from filtered lines
      rise = s.scl_f & ~s.scl_p;
      fall = ~s.scl_f & s.scl_p;
      start = s.scl_f & s.scl_p & s.sda_p & ~s.sda_f;
      stop = s.scl_f & s.scl_p & ~s.sda_p & s.sda_f;
      alert_on = ~s.alert_oe_n;

      // read data selected by the held pointer
      case (s.ptr)
         smbus_sensor_pkg::PTR_LOCAL: rdb = s.local_res;
         smbus_sensor_pkg::PTR_REMOTE: rdb = s.remote_res;
         smbus_sensor_pkg::PTR_STATUS: begin
            rdb = 8'h00;
            rdb[smbus_sensor_pkg::STAT_BUSY_BIT] = s.conv_on;
         end
         smbus_sensor_pkg::PTR_CFG_RD: rdb = s.cfg;
         default: rdb = 8'h00;
      endcase
      if (s.ara) begin
         rdb = {own, alert_high};
      end

      // conversion sequencing
      if (s.conv_on) begin
         if (s.cfg[smbus_sensor_pkg::CFG_SHUTDOWN_BIT] & ~s.single) begin
            n.conv_on = 1'b0;
         end else if (s.cv_cnt == smbus_sensor_pkg::CV_W'(CONV_CYCLES - 1)) begin
            n.conv_on = 1'b0;
            n.single = 1'b0;
            n.hold = 1'b0;
            if (supply_ok) begin
               n.local_res = local_meas;
               n.remote_res = remote_meas;
            end
         end else begin
            n.cv_cnt = s.cv_cnt + smbus_sensor_pkg::CV_W'(1);
         end
      end else if (supply_ok & ~s.cfg[smbus_sensor_pkg::CFG_SHUTDOWN_BIT]) begin
         n.conv_on = 1'b1;
         n.cv_cnt = '0;
      end else if (supply_ok & s.shot_req) begin
         n.conv_on = 1'b1;
         n.single = 1'b1;
         n.shot_req = 1'b0;
         n.cv_cnt = '0;
      end
      if (~s.cfg[smbus_sensor_pkg::CFG_SHUTDOWN_BIT] | ~supply_ok) begin
         n.shot_req = 1'b0;
      end

      // frame timeout counter
      if (s.in_xfer & (~s.scl_f | ~s.sda_f)) begin
         n.to_cnt = s.to_cnt + smbus_sensor_pkg::TO_W'(1);
      end else begin
         n.to_cnt = '0;
      end

      // bus protocol
      if (start) begin
         n.in_xfer = 1'b1;
         n.st = ST_ADDR;
         n.first = 1'b1;
         n.bits = 4'h0;
         n.sda_oe_n = 1'b1;
         n.to_cnt = '0;
      end else if (stop) begin
         n.in_xfer = 1'b0;
         n.hs = 1'b0;
         n.st = ST_IDLE;
         n.sda_oe_n = 1'b1;
      end else if (s.to_cnt == smbus_sensor_pkg::TO_W'(TIMEOUT_CYCLES - 1)) begin
         n.in_xfer = 1'b0;
         n.st = ST_IDLE;
         n.sda_oe_n = 1'b1;
         n.to_cnt = '0;
      end else begin
         case (s.st)
            ST_ADDR, ST_WR: begin
               if (rise) begin
                  n.sh = {s.sh[6:0], s.sda_f};
                  n.bits = s.bits + 4'h1;
               end else if (fall & (s.bits == 4'h8)) begin
                  n.bits = 4'h0;
                  if (s.st == ST_ADDR) begin
                     n.first = 1'b0;
                     n.nbyte = 1'b0;
                     n.gc = 1'b0;
                     n.ara = 1'b0;
                     n.rd = s.sh[0];
                     n.st = ST_AACK;
                     n.sda_oe_n = 1'b0;
                     if (s.first & (s.sh[7:3] == smbus_sensor_pkg::HS_CODE)) begin
                        n.hs = 1'b1;
                        n.st = ST_IGN;
                        n.sda_oe_n = 1'b1;
                     end else if (s.sh == smbus_sensor_pkg::GCALL_ADDR) begin
                        n.gc = 1'b1;
                     end else if ((s.sh == smbus_sensor_pkg::ALERT_RESP) & alert_on) begin
                        n.ara = 1'b1;
                     end else if (s.sh[7:1] != own) begin
                        n.st = ST_IGN;
                        n.sda_oe_n = 1'b1;
                     end
                  end else begin
                     n.st = ST_WACK;
                     n.sda_oe_n = 1'b0;
                     n.nbyte = 1'b1;
                     if (s.gc) begin
                        if (~s.nbyte & (s.sh == smbus_sensor_pkg::GCALL_RESET)) begin
                           sw_rst = 1'b1;
                        end
                     end else if (~s.nbyte) begin
                        n.ptr = s.sh;
                     end else begin
                        case (s.ptr)
                           smbus_sensor_pkg::PTR_CFG_WR: n.cfg = s.sh;
                           smbus_sensor_pkg::PTR_ONE_SHOT: begin
                              // data byte itself is dropped
                              n.shot_req = s.cfg[smbus_sensor_pkg::CFG_SHUTDOWN_BIT];
                           end
                           smbus_sensor_pkg::PTR_SW_RESET: sw_rst = 1'b1;
                           default: n.st = ST_WACK;
                        endcase
                     end
                  end
               end
            end
            ST_AACK: begin
               if (fall) begin
                  if (s.rd) begin
                     n.st = ST_RD;
                     n.sda_oe_n = rdb[7];
                     n.tx = {rdb[6:0], 1'b0};
                     n.bits = 4'h1;
                  end else if (s.ara) begin
                     n.st = ST_IGN; // write-direction alert response
                     n.sda_oe_n = 1'b1;
                  end else begin
                     n.st = ST_WR;
                     n.sda_oe_n = 1'b1;
                  end
               end
            end
            ST_WACK: begin
               if (fall) begin
                  n.st = ST_WR;
                  n.sda_oe_n = 1'b1;
               end
            end
            ST_RD: begin
               if (rise & s.ara & s.sda_oe_n & ~s.sda_f) begin
                  n.st = ST_IGN;
                  n.ara = 1'b0;
               end else if (fall) begin
                  if (s.bits == 4'h8) begin
                     n.st = ST_RACK;
                     n.sda_oe_n = 1'b1;
                     n.bits = 4'h0;
                     if (s.ara) begin
                        n.cfg[smbus_sensor_pkg::CFG_MASK_BIT] = 1'b1;
                     end
                  end else begin
                     n.sda_oe_n = s.tx[7];
                     n.tx = {s.tx[6:0], 1'b0};
                     n.bits = s.bits + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (rise) begin
                  n.mack = ~s.sda_f;
               end else if (fall) begin
                  if (s.mack & ~s.ara) begin
                     n.st = ST_RD;
                     n.sda_oe_n = rdb[7];
                     n.tx = {rdb[6:0], 1'b0};
                     n.bits = 4'h1;
                  end else begin
                     n.st = ST_IGN;
                  end
               end
            end
            ST_IDLE, ST_IGN: n.sda_oe_n = 1'b1;
            default: begin
               n.st = ST_IDLE;
               n.sda_oe_n = 1'b1;
            end
         endcase
      end

      // software reset restores registers, aborts and quiets alarms
      if (sw_rst) begin
         n.cfg = smbus_sensor_pkg::CFG_RST;
         n.ptr = smbus_sensor_pkg::PTR_RST;
         n.local_res = smbus_sensor_pkg::TEMP_RST;
         n.remote_res = smbus_sensor_pkg::TEMP_RST;
         n.conv_on = 1'b0;
         n.single = 1'b0;
         n.shot_req = 1'b0;
         n.hold = 1'b1;
      end

      // alarm drive; hold releases both until a fresh result exists
      n.alert_oe_n = ~(alert_cond & ~n.cfg[smbus_sensor_pkg::CFG_MASK_BIT] & ~n.hold);
      n.trip_oe_n = ~(overtemp_cond & ~n.hold);
      if (s.ara & (s.st == ST_RD)) begin
         n.alert_oe_n = s.alert_oe_n; // keep alert asserted during arbitration
      end
      n.pin_low = 1'b0;
   end

   // single state register; async reset loads constants only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.scl_m <= 1'b1;
         s.scl_s <= 1'b1;
         s.sda_m <= 1'b1;
         s.sda_s <= 1'b1;
         s.scl_f <= 1'b1;
         s.sda_f <= 1'b1;
         s.scl_p <= 1'b1;
         s.sda_p <= 1'b1;
         s.st <= ST_IDLE;
         s.cfg <= smbus_sensor_pkg::CFG_RST;
         s.ptr <= smbus_sensor_pkg::PTR_RST;
         s.sda_oe_n <= 1'b1;
         s.alert_oe_n <= 1'b1;
         s.trip_oe_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // outputs taken straight from the state register
   assign sda_o = s.pin_low;
   assign sda_oe_n = s.sda_oe_n;
   assign alert_o = s.pin_low;
   assign alert_oe_n = s.alert_oe_n;
   assign overtemp_trip_out_n = s.pin_low;
   assign overtemp_trip_oe_n = s.trip_oe_n;
   assign conv_busy = s.conv_on;
endmodule

/* verilog/smbus_sensor_pkg.sv */
// Purpose: constants for the sensor two-wire slave and conversion control
// Assumes: 100 MHz core clock
// Notes: pin levels are filtered in the core clock domain
// Functional notes
// - setting shutdown_bit stops conversions immediately, aborting any in progress
// - with shutdown_bit clear, conversions run back to back
// - in shutdown, a write to pointer 0Fh runs one conversion, then shutdown
// - the one-shot data byte is dropped, never stored
// - slave only; every byte shifts most significant bit first
// - matching address is acknowledged by pulling SDA low on clock nine
// - SDA fall with SCL high is START, SDA rise with SCL high is STOP
// - one fixed seven-bit address, chosen by variant, plus direction bit
// - first byte of every write to the own address loads the register pointer
// - reads use the last written pointer, which persists until rewritten or cleared by software reset
// - without valid supply, skip conversions and keep the last result
// - a line low 32 ms inside a frame resets the interface
// - fast-mode to 400 kHz and high-speed to 2.5 MHz
// - master code 00001xxx is not acknowledged and selects high-speed filters
// - high-speed filtering lasts over restarts and ends at STOP
// - general call acknowledged; second byte 06h resets registers and alarms
// - other general call second bytes change nothing
// - alert-response read acknowledged while alert active, replies own address
// - reply last bit high for high limit, low for low limit
// - after the reply, the alert mask bit is set
// - lost arbitration in the reply leaves alert state untouched
package smbus_sensor_pkg;
   // slave addresses and special bus codes
   localparam logic [6:0] ADDR_A = 7'h4C;
   localparam logic [6:0] ADDR_B = 7'h4D;
   localparam logic [7:0] GCALL_ADDR = 8'h00;
   localparam logic [7:0] GCALL_RESET = 8'h06;
   localparam logic [7:0] ALERT_RESP = 8'h19;
   localparam logic [4:0] HS_CODE = 5'h01;
   // register pointers
   localparam logic [7:0] PTR_LOCAL = 8'h00;
   localparam logic [7:0] PTR_REMOTE = 8'h01;
   localparam logic [7:0] PTR_STATUS = 8'h02;
   localparam logic [7:0] PTR_CFG_RD = 8'h03;
   localparam logic [7:0] PTR_CFG_WR = 8'h09;
   localparam logic [7:0] PTR_ONE_SHOT = 8'h0F;
   localparam logic [7:0] PTR_SW_RESET = 8'hFC;
   // field positions and reset values
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_SHUTDOWN_BIT = 6;
   localparam int STAT_BUSY_BIT = 7;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] TEMP_RST = 8'h00;
   // line filter spans in cycles
   localparam logic [2:0] FILT_FAST = 3'h4;
   localparam logic [2:0] FILT_HS = 3'h1;
   // times and derived counts
   localparam int CLK_MHZ = 100;
   localparam int TIMEOUT_MS = 32;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int CONV_TIME_US = 100;
   localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
   localparam int TO_W = 22;
   localparam int CV_W = 16;
endpackage

/* sim/smbus_sensor_assertions.sv */
// Purpose: port-level checks of the sensor two-wire slave
// Assumes: scl low phases outlast the slave's answer delay
// Notes: bound into every smbus_sensor_slave instance
`timescale 1ns/10ps
module smbus_sensor_assertions #(
   parameter int TIMEOUT_CYCLES = 2000
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // bus and alarm pins
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic alert_o,
   input wire logic alert_oe_n,
   input wire logic overtemp_trip_out_n,
   input wire logic overtemp_trip_oe_n,
   // measurement side
   input wire logic supply_ok,
   input wire logic alert_cond,
   input wire logic overtemp_cond,
   input wire logic conv_busy
);
   int low_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // length of the current scl low stretch
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= scl_i ? 0 : low_cnt + 1;
      end
   end
   a_sda_scl_low: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
      else $error("slave sda drive moved while scl high");
   a_ack_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*4])
      else $error("slave pull-down shorter than a bit");
   a_timeout_free: assert property (low_cnt > TIMEOUT_CYCLES + 40 |-> sda_oe_n)
      else $error("sda held past the bus timeout");
   a_open_drain: assert property (!sda_o && !alert_o && !overtemp_trip_out_n)
      else $error("open-drain pin driven high");
   a_alert_release: assert property ($rose(alert_oe_n) && alert_cond |-> !scl_i)
      else $error("alert released outside a bus low phase");
   a_alert_cause: assert property ($fell(alert_oe_n) |-> alert_cond)
      else $error("alert asserted without a cause");
   a_trip_cause: assert property ($fell(overtemp_trip_oe_n) |-> overtemp_cond)
      else $error("trip asserted without a cause");
   a_busy_supply: assert property ($rose(conv_busy) |-> $past(supply_ok))
      else $error("conversion started without a valid supply");
endmodule
bind smbus_sensor_slave smbus_sensor_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);

/* sim/smbus_master_model.sv */
// Purpose: behavioural two-wire bus master driving the slave pins
// Assumes: sda_in is the wired-and level with the pull-up applied
// Notes: long low phases leave room for the slave's filter delay
`timescale 1ns/10ps
module smbus_master_model #(
   parameter int Q = 12
) (
   // clock
   input wire logic mclk,
   // bus
   input wire logic sda_in,
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic ph();
      repeat (Q) @(negedge mclk);
   endtask
   // start or repeated start, sda falls while scl high
   task automatic start();
      ph();
      sda = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sda = 1'b0;
      ph();
      scl = 1'b0;
   endtask
   // stop, sda rises while scl high
   task automatic stop();
      ph();
      sda = 1'b0;
      ph();
      scl = 1'b1;
      ph();
      sda = 1'b1;
   endtask
   // data moves only mid-low, sampled at the end of high
   task automatic bit_x(input logic b, output logic r);
      ph();
      sda = b;
      ph();
      scl = 1'b1;
      ph();
      ph();
      r = sda_in;
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // last byte of a read is not acknowledged
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(last, r);
   endtask
endmodule

/* sim/testbench.sv */
// Purpose: self-checking bench for the sensor two-wire slave
// Assumes: slave answers well inside one scl low phase
// Notes: short timeout and conversion counts keep the run brief
`timescale 1ns/10ps
`define CHK(g, e) begin \
   compares++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("[FAIL] %0t got %h expected %h", $time, g, e); \
   end \
end
module testbench;
   logic mclk, rst_n, supply_ok, alert_cond, alert_high, overtemp_cond;
   logic [7:0] local_meas, remote_meas, rd;
   logic scl, m_sda, sda_o, sda_oe_n, sda_w, alert_oe_n, conv_busy, ack;
   logic trip_oe_n;
   int err_count, compares;
   // pull-up on sda, any party may pull low
   assign sda_w = m_sda & (sda_oe_n | sda_o);
   smbus_master_model #(.Q(12)) u_mst (.mclk(mclk), .sda_in(sda_w), .scl(scl), .sda(m_sda));
   smbus_sensor_slave #(.VARIANT_B(1'b0), .TIMEOUT_CYCLES(2000), .CONV_CYCLES(50)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .alert_o(), .alert_oe_n(alert_oe_n), .overtemp_trip_out_n(),
      .overtemp_trip_oe_n(trip_oe_n), .supply_ok(supply_ok), .local_meas(local_meas),
      .remote_meas(remote_meas), .alert_cond(alert_cond), .alert_high(alert_high),
      .overtemp_cond(overtemp_cond), .conv_busy(conv_busy));
   task automatic wait_c(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // address, pointer and one data byte
   task automatic wreg(input logic [7:0] p, input logic [7:0] d);
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::ADDR_A, 1'b0}, ack);
      `CHK(ack, 1'b1)
      u_mst.wbyte(p, ack);
      u_mst.wbyte(d, ack);
      u_mst.stop();
   endtask
   // pointer-only write, restart, two reads of one register
   task automatic rreg(input logic [7:0] p, input logic [7:0] e);
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::ADDR_A, 1'b0}, ack);
      u_mst.wbyte(p, ack);
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::ADDR_A, 1'b1}, ack);
      u_mst.rbyte(1'b0, rd);
      `CHK(rd, e)
      u_mst.rbyte(1'b1, rd);
      `CHK(rd, e)
      u_mst.stop();
   endtask
   task automatic give_verdict();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // hang guard, well beyond the expected run length
   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      supply_ok = 1'b1;
      alert_cond = 1'b0;
      alert_high = 1'b0;
      overtemp_cond = 1'b1;
      local_meas = 8'h5A;
      remote_meas = 8'hC3;
      wait_c(6);
      rst_n = 1'b1;
      wait_c(20);
      `CHK(conv_busy, 1'b1)
      wait_c(120);
      overtemp_cond = 1'b0;
      rreg(smbus_sensor_pkg::PTR_LOCAL, 8'h5A);
      rreg(smbus_sensor_pkg::PTR_REMOTE, 8'hC3);
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::ADDR_B, 1'b0}, ack);
      `CHK(ack, 1'b0)
      u_mst.stop();
      // shutdown, then writes to a read-only place and the one-shot trigger
      wreg(smbus_sensor_pkg::PTR_CFG_WR, 8'h40);
      wait_c(3);
      `CHK(conv_busy, 1'b0)
      local_meas = 8'h21;
      wait_c(100);
      `CHK(conv_busy, 1'b0)
      wreg(smbus_sensor_pkg::PTR_LOCAL, 8'hFF);
      rreg(smbus_sensor_pkg::PTR_LOCAL, 8'h5A);
      wreg(smbus_sensor_pkg::PTR_ONE_SHOT, 8'hA5);
      wait_c(100);
      `CHK(conv_busy, 1'b0)
      rreg(smbus_sensor_pkg::PTR_LOCAL, 8'h21);
      rreg(smbus_sensor_pkg::PTR_CFG_RD, 8'h40);
      supply_ok = 1'b0;
      local_meas = 8'h33;
      wreg(smbus_sensor_pkg::PTR_ONE_SHOT, 8'h00);
      wait_c(100);
      rreg(smbus_sensor_pkg::PTR_LOCAL, 8'h21);
      supply_ok = 1'b1;
      // read whose first data bit is low, then scl stuck low
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::ADDR_A, 1'b1}, ack);
      wait_c(30);
      `CHK(sda_oe_n, 1'b0)
      wait_c(2100);
      `CHK(sda_oe_n, 1'b1)
      u_mst.stop();
      // general call with a foreign code, then with the reset code
      u_mst.start();
      u_mst.wbyte(smbus_sensor_pkg::GCALL_ADDR, ack);
      `CHK(ack, 1'b1)
      u_mst.wbyte(8'h55, ack);
      u_mst.stop();
      rreg(smbus_sensor_pkg::PTR_CFG_RD, 8'h40);
      // both alarms pending, the reset must drop them before a fresh result
      overtemp_cond = 1'b1;
      alert_cond = 1'b1;
      u_mst.start();
      u_mst.wbyte(smbus_sensor_pkg::GCALL_ADDR, ack);
      `CHK(trip_oe_n, 1'b0)
      `CHK(alert_oe_n, 1'b0)
      u_mst.wbyte(smbus_sensor_pkg::GCALL_RESET, ack);
      `CHK(trip_oe_n, 1'b1)
      `CHK(alert_oe_n, 1'b1)
      overtemp_cond = 1'b0;
      alert_cond = 1'b0;
      u_mst.stop();
      rreg(smbus_sensor_pkg::PTR_CFG_RD, smbus_sensor_pkg::CFG_RST);
      // alert response with no alert pending is ignored
      u_mst.start();
      u_mst.wbyte(smbus_sensor_pkg::ALERT_RESP, ack);
      `CHK(ack, 1'b0)
      u_mst.stop();
      // alert response for each cause, unmasked again by software
      for (int h = 1; h >= 0; h--) begin
         alert_cond = 1'b1;
         alert_high = h[0];
         wait_c(150);
         `CHK(alert_oe_n, 1'b0)
         u_mst.start();
         u_mst.wbyte(smbus_sensor_pkg::ALERT_RESP, ack);
         `CHK(ack, 1'b1)
         u_mst.rbyte(1'b1, rd);
         `CHK(rd, {smbus_sensor_pkg::ADDR_A, h[0]})
         u_mst.stop();
         wait_c(5);
         `CHK(alert_oe_n, 1'b1)
         rreg(smbus_sensor_pkg::PTR_CFG_RD, 8'h80);
         wreg(smbus_sensor_pkg::PTR_CFG_WR, 8'h00);
      end
      alert_cond = 1'b0;
      // high-speed master code, then a read across the restart
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::HS_CODE, 3'h1}, ack);
      `CHK(ack, 1'b0)
      u_mst.start();
      u_mst.wbyte({smbus_sensor_pkg::ADDR_A, 1'b1}, ack);
      `CHK(ack, 1'b1)
      u_mst.rbyte(1'b1, rd);
      `CHK(rd, 8'h00)
      u_mst.stop();
      give_verdict();
   end
endmodule
